// *** bench/ohc_line_model.sv ***
// Host side of the overheat line: open-drain wire with pull-up
`default_nettype none
module ohc_line_model (
  input wire logic clk_i,
  input wire logic hold_req_i,
  input wire logic dev_oe_i,
  input wire logic dev_n_i,
  output logic line_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low_r = 1'b0;
  // Host changes the line only after an edge and holds it whole cycles
  always @(posedge clk_i) begin
    host_low_r <= hold_req_i;
  end
  // Wired level: pulled high unless either party pulls low
  assign line_n_o = !(host_low_r || (dev_oe_i && !dev_n_i));
endmodule : ohc_line_model
`default_nettype wire

// *** bench/ohc_top_bench.sv ***
// Self-checking bench for the overheat timer and pin role block
`default_nettype none
module ohc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [9:0] address_i = 10'h000;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [3:0] fan_drive_i = 4'h0;
  logic ovh_drive_req_i = 1'b0;
  logic gpio_out_i = 1'b0;
  logic gpio_oe_i = 1'b0;
  logic host_req = 1'b0;
  logic pin14_n = 1'b1;
  logic [31:0] readdata_o;
  logic waitrequest_o, irq_o, pin10_o, pin22_n_o, pin22_oe_o, pin14_o, pin14_oe_o;
  logic tach_tick_o, pin22_is_ovh_o, line_n;
  logic [3:0] fan_drive_o, continuous_speed_o, stretch_en_o;
  logic [1:0] pin14_role_o;
  logic [7:0] rnd = 8'h51;
  int tests_run = 0;
  int mismatches = 0;
  int cycles = 0;
  int cfg_m = 0;
  int pctl_m = 0;

  ohc_top #(.STEP_CYCLES(16), .SLOW_CYCLES(40), .QUICK_CYCLES(10)) i_dut (
    .clk_i, .arst_n_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
    .waitrequest_o, .irq_o, .fan_drive_i, .fan_drive_o, .pin10_o,
    .pin22_n_i(line_n), .pin22_n_o, .pin22_oe_o, .pin14_i(pin14_n), .pin14_o,
    .pin14_oe_o, .ovh_drive_req_i, .gpio_out_i, .gpio_oe_i, .tach_tick_o,
    .continuous_speed_o, .stretch_en_o, .pin22_is_ovh_o, .pin14_role_o
  );
  ohc_line_model i_host (.clk_i, .hold_req_i(host_req), .dev_oe_i(pin22_oe_o),
    .dev_n_i(pin22_n_o), .line_n_o(line_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    address_i <= {idx, 2'h0};
    writedata_i <= {24'h000000, d};
    read_i <= !wr;
    write_i <= wr;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0) @(posedge clk_i);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(negedge clk_i);
  endtask : bus

  // Write, mirrored into the reference registers
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
    if (pctl_m[0] == 0 && idx == 8'h78) cfg_m = d;
    if (pctl_m[0] == 0 && idx == 8'h80) pctl_m = d & 8'h07;
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h000000, exp});
  endtask : rd_chk

  // Cycles between two tach ticks
  task automatic gap(output int g);
    g = 1;
    @(negedge clk_i);
    while (tach_tick_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    while (tach_tick_o !== 1'b1) begin
      @(negedge clk_i);
      g++;
    end
  endtask : gap

  task automatic hold_line(input int n);
    @(posedge clk_i);
    host_req <= 1'b1;
    repeat (n) @(posedge clk_i);
    host_req <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : hold_line

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int g;
    logic [31:0] q;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk(8'h78, 8'h00);
    rd_chk(8'h79, 8'h00);
    rd_chk(8'h7F, 8'h00);
    // Random configurations: fan modes and pin 10 role
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk_i);
      fan_drive_i <= rnd[7:4];
      wr(8'h78, rnd);
      rd_chk(8'h78, cfg_m[7:0]);
      repeat (2) @(negedge clk_i);
      chk(continuous_speed_o, rnd[7:4]);
      chk(stretch_en_o, 4'(~rnd[7:4]));
      chk(fan_drive_o, rnd[7:4]);
      chk(pin10_o, rnd[0] ? !irq_o : rnd[5]);
    end
    // Every pin-14 code with the overheat enable off and on
    for (int c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      @(posedge clk_i);
      gpio_out_i <= rnd[0];
      gpio_oe_i <= rnd[1];
      wr(8'h78, {6'h00, c[2], 1'b0});
      wr(8'h80, {5'h00, c[1:0], 1'b0});
      @(negedge clk_i);
      chk(pin22_is_ovh_o, c[2] && c[1:0] != 2'h1);
      chk(pin14_role_o, c[1:0]);
      chk({pin14_oe_o, pin14_o}, c[1] ? (c[0] ? rnd[1:0] : 2'h3) : 2'h0);
    end
    // Device drives the overheat line itself
    wr(8'h80, 8'h00);
    wr(8'h78, 8'h07);
    @(posedge clk_i);
    ovh_drive_req_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk({pin22_oe_o, line_n}, 2'h2);
    @(posedge clk_i);
    ovh_drive_req_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(pin22_oe_o, 1'b0);
    rd_chk(8'h79, 8'h00);
    // Short assertion with limit zero: override, immediate interrupt
    wr(8'h82, 8'h03);
    wr(8'h7A, 8'h00);
    @(posedge clk_i);
    host_req <= 1'b1;
    repeat (9) @(negedge clk_i);
    chk(fan_drive_o, 4'hF);
    chk(irq_o, 1'b1);
    chk(pin10_o, 1'b0);
    @(posedge clk_i);
    host_req <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd_chk(8'h79, 8'h01);
    rd_chk(8'h79, 8'h00);
    rd_chk(8'h81, 8'h03);
    chk(irq_o, 1'b0);
    // Long assertion over a limit of two steps
    wr(8'h7A, 8'h02);
    hold_line(100);
    bus(1'b0, 8'h79, 8'h00, q);
    chk((q > 32'h4 && q < 32'h8) ? 32'h6 : q, 32'h6);
    wr(8'h82, 8'h00);
    chk(irq_o, 1'b0);
    wr(8'h82, 8'h03);
    chk(irq_o, 1'b1);
    rd_chk(8'h81, 8'h03);
    chk(irq_o, 1'b0);
    // Tach rate, slow then quick
    gap(g);
    gap(g);
    chk(g, 40);
    wr(8'h78, 8'h08);
    gap(g);
    gap(g);
    chk(g, 10);
    // Overheat sensed on pin 14 with code 01
    wr(8'h80, 8'h02);
    @(posedge clk_i);
    pin14_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    pin14_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_chk(8'h79, 8'h01);
    // Lock: later configuration and pin control writes are ignored
    wr(8'h80, 8'h01);
    wr(8'h78, 8'hA5);
    wr(8'h80, 8'h06);
    rd_chk(8'h78, 8'h08);
    @(negedge clk_i);
    chk(pin14_role_o, 2'h0);
    report_and_stop();
  end
endmodule : ohc_top_bench
`default_nettype wire

// *** design/ohc_pin_if.sv ***
// Interface carrying one pin between its synchroniser and the user logic
`default_nettype none
interface ohc_pin_if;
  logic raw;
  logic level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : ohc_pin_if
`default_nettype wire

// *** design/ohc_pkg.sv ***
// Package of constants for the overheat timer and pin configuration block
`default_nettype none
package ohc_pkg;
  // Clock and times
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned STEP_US = 22760;
  localparam int unsigned STEP_CYC = STEP_US * CLK_KHZ / 1000;
  localparam int unsigned SLOW_MS = 1000;
  localparam int unsigned QUICK_MS = 250;
  localparam int unsigned SLOW_CYC = SLOW_MS * CLK_KHZ;
  localparam int unsigned QUICK_CYC = QUICK_MS * CLK_KHZ;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_CFG = 8'h78;
  localparam logic [7:0] IDX_STAT = 8'h79;
  localparam logic [7:0] IDX_LIMIT = 8'h7A;
  localparam logic [7:0] IDX_PCTL = 8'h80;
  localparam logic [7:0] IDX_ISTAT = 8'h81;
  localparam logic [7:0] IDX_IMASK = 8'h82;
  // Configuration fields
  localparam int CFG_ALERT = 0;
  localparam int CFG_OHEN = 1;
  localparam int CFG_FULL = 2;
  localparam int CFG_QUICK = 3;
  localparam int CFG_DC = 4;
  // Pin control fields
  localparam int PCTL_LOCK = 0;
  localparam int PCTL_P14 = 1;
  // Interrupt status fields
  localparam int IRQ_ASRT = 0;
  localparam int IRQ_LIMIT = 1;
  // Reset values and misc
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CNT_SHOWN = 8'h02;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int ECHO_CYC = 6;
  // Pin 14 roles
  typedef enum logic [1:0] {
    P14_TACH = 2'h0,
    P14_OVH = 2'h1,
    P14_ALERT = 2'h2,
    P14_GPIO = 2'h3
  } ohc_p14_t;
  // Timer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_TIME = 2'h2
  } ohc_st_t;
endpackage : ohc_pkg
`default_nettype wire

// *** design/ohc_sync3.sv ***
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module ohc_sync3 (
  input wire logic clk_i,
  input wire logic arst_n_i,
  ohc_pin_if.sync p
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // Shift chain, idle level high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= 1'h1;
      s2_r <= 1'h1;
      s3_r <= 1'h1;
    end else begin
      s1_r <= p.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level follows once stages two and three agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_r <= 1'h1;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign p.level = level_r;
endmodule : ohc_sync3
`default_nettype wire

// *** design/ohc_top.sv ***
// Overheat timer, pin roles and fan mode block with Avalon-MM slave
`default_nettype none
module ohc_top #(
  parameter int unsigned STEP_CYCLES = ohc_pkg::STEP_CYC,
  parameter int unsigned SLOW_CYCLES = ohc_pkg::SLOW_CYC,
  parameter int unsigned QUICK_CYCLES = ohc_pkg::QUICK_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [9:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic irq_o,
  input wire logic [3:0] fan_drive_i,
  output logic [3:0] fan_drive_o,
  output logic pin10_o,
  input wire logic pin22_n_i,
  output logic pin22_n_o,
  output logic pin22_oe_o,
  input wire logic pin14_i,
  output logic pin14_o,
  output logic pin14_oe_o,
  input wire logic ovh_drive_req_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic tach_tick_o,
  output logic [3:0] continuous_speed_o,
  output logic [3:0] stretch_en_o,
  output logic pin22_is_ovh_o,
  output logic [1:0] pin14_role_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ack_r;
  logic req;
  logic acc;
  logic [7:0] idx;
  logic [7:0] cfg_r;
  logic [7:0] limit_r;
  logic lock_r;
  ohc_pkg::ohc_p14_t p14_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic seen_r;
  logic [7:0] cnt_r;
  ohc_pkg::ohc_st_t st_r;
  logic [19:0] step_cnt_r;
  logic step_tick;
  logic [25:0] tach_cnt_r;
  logic [25:0] tach_lim;
  logic hit_r;
  logic hit;
  logic [1:0] lvl;
  logic p22_ovh;
  logic p14_ovh;
  logic ovh_n;
  logic active;
  logic [ohc_pkg::ECHO_CYC-1:0] drv_hist_r;
  logic rise;
  logic full_on;
  logic [7:0] stat_val;
  logic rd_stat;
  logic rd_istat;
  logic [31:0] rdata_nxt;

  // Decode used for every register access
  function automatic logic hit_idx(input logic [7:0] a, input logic [7:0] b);
    hit_idx = (a == b);
  endfunction : hit_idx

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] pin_raw;
  assign pin_raw = {pin14_i, pin22_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      ohc_pin_if pif ();
      assign pif.raw = pin_raw[gi];
      assign lvl[gi] = pif.level;
      ohc_sync3 u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .p(pif)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access
  assign req = read_i | write_i;
  assign acc = req & ack_r;
  assign idx = address_i[9:2];
  assign waitrequest_o = req & ~ack_r;
  assign rd_stat = acc & read_i & hit_idx(idx, ohc_pkg::IDX_STAT);
  assign rd_istat = acc & read_i & hit_idx(idx, ohc_pkg::IDX_ISTAT);

  // Acknowledge toggles so each request completes on its second edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_idx(idx, ohc_pkg::IDX_CFG)) begin
      rdata_nxt[7:0] = cfg_r;
    end else if (hit_idx(idx, ohc_pkg::IDX_STAT)) begin
      rdata_nxt[7:0] = stat_val;
    end else if (hit_idx(idx, ohc_pkg::IDX_LIMIT)) begin
      rdata_nxt[7:0] = limit_r;
    end else if (hit_idx(idx, ohc_pkg::IDX_PCTL)) begin
      rdata_nxt[2:0] = {p14_r, lock_r};
    end else if (hit_idx(idx, ohc_pkg::IDX_ISTAT)) begin
      rdata_nxt[1:0] = istat_r;
    end else if (hit_idx(idx, ohc_pkg::IDX_IMASK)) begin
      rdata_nxt[1:0] = imask_r;
    end
  end

  // Read data captured the cycle before completion
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & ~ack_r) begin
      readdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r <= ohc_pkg::REG_RST;
    end else if (acc & write_i & hit_idx(idx, ohc_pkg::IDX_CFG) & ~lock_r) begin
      cfg_r <= writedata_i[7:0];
    end
  end

  // Lock is sticky until reset; pin-14 code is locked with it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_r <= 1'h0;
      p14_r <= ohc_pkg::P14_TACH;
    end else if (acc & write_i & hit_idx(idx, ohc_pkg::IDX_PCTL) & ~lock_r) begin
      lock_r <= writedata_i[ohc_pkg::PCTL_LOCK];
      p14_r <= ohc_pkg::ohc_p14_t'(writedata_i[ohc_pkg::PCTL_P14 +: 2]);
    end
  end

  // Limit and interrupt mask
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      limit_r <= ohc_pkg::REG_RST;
      imask_r <= 2'h0;
    end else if (acc & write_i) begin
      if (hit_idx(idx, ohc_pkg::IDX_LIMIT)) begin
        limit_r <= writedata_i[7:0];
      end
      if (hit_idx(idx, ohc_pkg::IDX_IMASK)) begin
        imask_r <= writedata_i[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin roles and overheat sensing
  assign p14_ovh = (p14_r == ohc_pkg::P14_OVH);
  assign p22_ovh = cfg_r[ohc_pkg::CFG_OHEN] & ~p14_ovh;
  assign ovh_n = p14_ovh ? lvl[1] : lvl[0];
  // Own drive is not taken as an outside assertion
  assign active = (p22_ovh | p14_ovh) & ~ovh_n & ~ovh_drive_req_i & ~(|drv_hist_r);
  assign rise = active & (st_r == ohc_pkg::ST_IDLE);
  assign full_on = cfg_r[ohc_pkg::CFG_FULL] & active;
  assign pin22_is_ovh_o = p22_ovh;
  assign pin14_role_o = p14_r;

  // Own drive echoes through the synchroniser, so the mask outlasts the request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_hist_r <= {ohc_pkg::ECHO_CYC{1'h0}};
    end else begin
      drv_hist_r <= {drv_hist_r[ohc_pkg::ECHO_CYC-2:0], ovh_drive_req_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running prescalers
  assign step_tick = (step_cnt_r == 20'(STEP_CYCLES - 1));
  assign tach_lim = cfg_r[ohc_pkg::CFG_QUICK] ? 26'(QUICK_CYCLES - 1)
                                              : 26'(SLOW_CYCLES - 1);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_cnt_r <= 20'h0_0000;
    end else begin
      step_cnt_r <= step_tick ? 20'h0_0000 : step_cnt_r + 20'h0_0001;
    end
  end

  // Tach sample tick, once per second or every 250 ms
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tach_cnt_r <= 26'h000_0000;
      tach_tick_o <= 1'h0;
    end else if (tach_cnt_r >= tach_lim) begin
      tach_cnt_r <= 26'h000_0000;
      tach_tick_o <= 1'h1;
    end else begin
      tach_cnt_r <= tach_cnt_r + 26'h000_0001;
      tach_tick_o <= 1'h0;
    end
  end

  // Continuous-speed fans skip pulse stretching
  assign continuous_speed_o = cfg_r[ohc_pkg::CFG_DC +: 4];
  assign stretch_en_o = ~cfg_r[ohc_pkg::CFG_DC +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Assertion timer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ohc_pkg::ST_IDLE;
      cnt_r <= ohc_pkg::REG_RST;
    end else begin
      case (st_r)
        ohc_pkg::ST_IDLE: begin
          if (active) begin
            st_r <= ohc_pkg::ST_TIME;
            cnt_r <= 8'h00;
          end
        end
        ohc_pkg::ST_TIME: begin
          if (!active) begin
            st_r <= ohc_pkg::ST_IDLE;
          end else if (step_tick && cnt_r != ohc_pkg::CNT_MAX) begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: begin
          st_r <= ohc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Seen flag: new assertion wins over a clearing read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_r <= 1'h0;
    end else if (rise) begin
      seen_r <= 1'h1;
    end else if (rd_stat) begin
      seen_r <= 1'h0;
    end
  end

  // Count shown only past two steps, bit 0 then joins it
  assign stat_val = (cnt_r >= ohc_pkg::CNT_SHOWN) ? cnt_r
                                                  : {7'h00, seen_r};

  ////////////////////////////////////////////////////////////////////////////
  // Limit check and interrupts
  assign hit = active & ((limit_r == 8'h00) | (st_r == ohc_pkg::ST_TIME & cnt_r > limit_r));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hit_r <= 1'h0;
    end else begin
      hit_r <= hit;
    end
  end

  // Sticky status, read clears, events win
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      istat_r <= 2'h0;
    end else begin
      istat_r[ohc_pkg::IRQ_ASRT] <= rise | (istat_r[ohc_pkg::IRQ_ASRT] & ~rd_istat);
      istat_r[ohc_pkg::IRQ_LIMIT] <= (hit & ~hit_r) |
                                     (istat_r[ohc_pkg::IRQ_LIMIT] & ~rd_istat);
    end
  end

  assign irq_o = |(istat_r & imask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin and fan outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fan_drive_o <= 4'h0;
      pin10_o <= 1'h1;
      pin22_n_o <= 1'h0;
      pin22_oe_o <= 1'h0;
      pin14_o <= 1'h0;
      pin14_oe_o <= 1'h0;
    end else begin
      fan_drive_o <= full_on ? 4'hF : fan_drive_i;
      if (cfg_r[ohc_pkg::CFG_ALERT]) begin
        pin10_o <= ~irq_o;
      end else begin
        pin10_o <= full_on | fan_drive_i[1];
      end
      pin22_n_o <= 1'h0;
      pin22_oe_o <= p22_ovh & ovh_drive_req_i;
      case (p14_r)
        ohc_pkg::P14_OVH: begin
          pin14_o <= 1'h0;
          pin14_oe_o <= ovh_drive_req_i;
        end
        ohc_pkg::P14_ALERT: begin
          pin14_o <= ~irq_o;
          pin14_oe_o <= 1'h1;
        end
        ohc_pkg::P14_GPIO: begin
          pin14_o <= gpio_out_i;
          pin14_oe_o <= gpio_oe_i;
        end
        default: begin
          pin14_o <= 1'h0;
          pin14_oe_o <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_start;
    rise ##1 (st_r == ohc_pkg::ST_TIME);
  endsequence

  alert_pin_a: assert property (cfg_r[0] |=> pin10_o == !$past(irq_o))
    else $error("pin 10 not alert");
  fan2_pin_a: assert property (!cfg_r[0] && !full_on |=> pin10_o == $past(fan_drive_i[1]))
    else $error("pin 10 not fan drive");
  pin22_role_a: assert property (p14_r == ohc_pkg::P14_OVH |-> !pin22_is_ovh_o)
    else $error("pin 22 role wrong");
  line_drive_a: assert property (p22_ovh && ovh_drive_req_i |=> pin22_oe_o && !pin22_n_o)
    else $error("line not driven");
  timer_start_a: assert property (s_start |-> cnt_r == 8'h00)
    else $error("timer not restarted");
  full_speed_a: assert property (full_on |=> fan_drive_o == 4'hF)
    else $error("fans not at full");
  lock_hold_a: assert property (lock_r |=> $stable(cfg_r))
    else $error("locked config changed");
  stat_low_a: assert property (read_i && !ack_r && cnt_r < 8'h02 &&
                               idx == ohc_pkg::IDX_STAT |=> readdata_o[7:1] == 7'h00)
    else $error("duration shown early");
  read_clear_a: assert property (rd_stat && !rise |=> !seen_r)
    else $error("seen flag not cleared");
  zero_limit_a: assert property (rise && limit_r == 8'h00 |=> istat_r[1])
    else $error("zero limit missed");
endmodule : ohc_top
`default_nettype wire
